// [src/ocp_ctrl.sv]
// Oscillator enables, stable flags, clock select and halt power modes.
`timescale 1ns/100ps
module ocp_ctrl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic crystal_pins_enabled,
   input wire logic slow_rc_stable,
   input wire logic fast_rc_stable,
   input wire logic halt_exec,
   input wire logic wake,
   output logic fast_crystal_osc_run,
   output logic fast_xtal_strong_drive,
   output logic slow_crystal_osc_run,
   output logic slow_xtal_speedup_out,
   output logic fast_clock_run,
   output logic sub_clock_run,
   output logic sys_clock_on_sub,
   output logic [2:0] fast_clock_div_sel,
   output logic cpu_halted,
   output logic watchdog_clear,
   output logic power_down_flag,
   output logic watchdog_timeout_flag,
   input wire logic watchdog_timeout
);
   logic fast_xtal_enable_ff;
   logic fast_xtal_drive_sel_ff;
   logic fast_xtal_stable_flag_ff;
   logic slow_xtal_enable_ff;
   logic slow_xtal_speedup_ff;
   logic slow_xtal_stable_flag_ff;
   logic [2:0] sys_clock_select_ff;
   logic low_freq_source_sel_ff;
   logic fast_osc_keepalive_ff;
   logic slow_osc_keepalive_ff;
   logic [11:0] fast_cnt_ff;
   logic [11:0] slow_cnt_ff;
   logic on_sub_ff;
   logic power_down_flag_ff;
   logic watchdog_timeout_flag_ff;
   logic watchdog_clear_ff;
   logic [7:0] rdata_ff;
   ocp_pkg::ocp_mode_type mode_ff;
   ocp_pkg::ocp_mode_type nxt_halt_mode;
   logic wr_fast;
   logic wr_slow;
   logic wr_cfg;
   logic sub_stable;
   logic slow_on_sub_now;
   logic fast_run_int;
   logic slow_run_int;
   logic [11:0] slow_target;

   assign wr_fast = wr && (addr == ocp_pkg::FAST_XTAL_ADDR);
   assign wr_slow = wr && (addr == ocp_pkg::SLOW_XTAL_ADDR);
   assign wr_cfg = wr && (addr == ocp_pkg::SYS_CFG_ADDR);

   // Drive select is locked while pins and fast crystal are both active.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fast_xtal_enable_ff <= 1'b0;
         fast_xtal_drive_sel_ff <= 1'b0;
      end else if (wr_fast) begin
         fast_xtal_enable_ff <= wdata[ocp_pkg::EN_BIT];
         if (!(crystal_pins_enabled && fast_xtal_enable_ff)) begin
            fast_xtal_drive_sel_ff <= wdata[ocp_pkg::MODE_BIT];
         end
      end
   end

   // The speed-up bit cannot change while the slow crystal clocks the core.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slow_xtal_enable_ff <= 1'b0;
         slow_xtal_speedup_ff <= 1'b0;
      end else if (wr_slow) begin
         slow_xtal_enable_ff <= wdata[ocp_pkg::EN_BIT];
         if (!slow_on_sub_now) begin
            slow_xtal_speedup_ff <= wdata[ocp_pkg::MODE_BIT];
         end
      end
   end

   assign slow_on_sub_now = on_sub_ff && low_freq_source_sel_ff;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sys_clock_select_ff <= ocp_pkg::CKS_RESET;
         low_freq_source_sel_ff <= 1'b0;
         fast_osc_keepalive_ff <= 1'b0;
         slow_osc_keepalive_ff <= 1'b0;
      end else if (wr_cfg) begin
         sys_clock_select_ff <= wdata[ocp_pkg::CKS_LSB +: 3];
         low_freq_source_sel_ff <= wdata[ocp_pkg::LFSEL_BIT];
         fast_osc_keepalive_ff <= wdata[ocp_pkg::KEEP_FAST_BIT];
         slow_osc_keepalive_ff <= wdata[ocp_pkg::KEEP_SLOW_BIT];
      end
   end

   // Stabilisation counters restart whenever an oscillator is (re)enabled.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fast_cnt_ff <= '0;
         fast_xtal_stable_flag_ff <= 1'b0;
      end else if (!fast_run_int
                   || (wr_fast && wdata[ocp_pkg::EN_BIT]
                       && !fast_xtal_enable_ff)) begin
         fast_cnt_ff <= '0;
         fast_xtal_stable_flag_ff <= 1'b0;
      end else if (fast_cnt_ff == 12'(ocp_pkg::FAST_STABLE_CYC)) begin
         fast_xtal_stable_flag_ff <= 1'b1;
      end else begin
         fast_cnt_ff <= fast_cnt_ff + 12'h001;
      end
   end

   assign slow_target = slow_xtal_speedup_ff
                        ? 12'(ocp_pkg::SLOW_SPEEDUP_CYC)
                        : 12'(ocp_pkg::SLOW_STABLE_CYC);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slow_cnt_ff <= '0;
         slow_xtal_stable_flag_ff <= 1'b0;
      end else if (!slow_run_int
                   || (wr_slow && wdata[ocp_pkg::EN_BIT]
                       && !slow_xtal_enable_ff)) begin
         slow_cnt_ff <= '0;
         slow_xtal_stable_flag_ff <= 1'b0;
      end else if (slow_cnt_ff >= slow_target) begin
         slow_xtal_stable_flag_ff <= 1'b1;
      end else begin
         slow_cnt_ff <= slow_cnt_ff + 12'h001;
      end
   end

   assign sub_stable = low_freq_source_sel_ff ? slow_xtal_stable_flag_ff
                                              : slow_rc_stable;

   // Fast mode follows the select at once; slow mode waits for stability.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         on_sub_ff <= 1'b0;
      end else if (sys_clock_select_ff != ocp_pkg::CKS_SUB) begin
         on_sub_ff <= 1'b0;
      end else if (sub_stable) begin
         on_sub_ff <= 1'b1;
      end
   end

   always_comb begin
      case ({fast_osc_keepalive_ff, slow_osc_keepalive_ff})
         2'b00: nxt_halt_mode = ocp_pkg::OCP_SLEEP;
         2'b01: nxt_halt_mode = ocp_pkg::OCP_IDLE_SUB;
         2'b11: nxt_halt_mode = ocp_pkg::OCP_IDLE_BOTH;
         default: nxt_halt_mode = ocp_pkg::OCP_IDLE_HIGH;
      endcase
   end

   // Halt freezes execution; register writes still apply and stopped crystals clear their stable flags.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_ff <= ocp_pkg::OCP_FAST;
      end else begin
         case (mode_ff)
            ocp_pkg::OCP_FAST, ocp_pkg::OCP_SLOW: begin
               if (halt_exec) begin
                  mode_ff <= nxt_halt_mode;
               end else begin
                  mode_ff <= on_sub_ff ? ocp_pkg::OCP_SLOW : ocp_pkg::OCP_FAST;
               end
            end
            default: begin
               if (wake) begin
                  mode_ff <= on_sub_ff ? ocp_pkg::OCP_SLOW : ocp_pkg::OCP_FAST;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         power_down_flag_ff <= 1'b0;
         watchdog_timeout_flag_ff <= 1'b0;
         watchdog_clear_ff <= 1'b0;
      end else begin
         watchdog_clear_ff <= halt_exec && !cpu_halted;
         if (halt_exec && !cpu_halted) begin
            power_down_flag_ff <= 1'b1;
            watchdog_timeout_flag_ff <= 1'b0;
         end else if (watchdog_timeout) begin
            watchdog_timeout_flag_ff <= 1'b1;
         end
      end
   end

   assign cpu_halted = (mode_ff != ocp_pkg::OCP_FAST)
                       && (mode_ff != ocp_pkg::OCP_SLOW);
   assign fast_run_int = fast_xtal_enable_ff
                         && (mode_ff != ocp_pkg::OCP_SLEEP)
                         && (mode_ff != ocp_pkg::OCP_IDLE_SUB);
   assign slow_run_int = slow_xtal_enable_ff
                         && (mode_ff != ocp_pkg::OCP_SLEEP)
                         && (mode_ff != ocp_pkg::OCP_IDLE_HIGH);
   assign fast_clock_run = (mode_ff == ocp_pkg::OCP_FAST)
                           || (mode_ff == ocp_pkg::OCP_SLOW)
                           || (mode_ff == ocp_pkg::OCP_IDLE_BOTH)
                           || (mode_ff == ocp_pkg::OCP_IDLE_HIGH);
   assign sub_clock_run = (mode_ff == ocp_pkg::OCP_FAST)
                          || (mode_ff == ocp_pkg::OCP_SLOW)
                          || (mode_ff == ocp_pkg::OCP_IDLE_BOTH)
                          || (mode_ff == ocp_pkg::OCP_IDLE_SUB);
   assign fast_crystal_osc_run = fast_run_int;
   assign slow_crystal_osc_run = slow_run_int;
   assign fast_xtal_strong_drive = fast_xtal_drive_sel_ff;
   assign slow_xtal_speedup_out = slow_xtal_speedup_ff;
   assign sys_clock_on_sub = on_sub_ff;
   assign fast_clock_div_sel = on_sub_ff ? ocp_pkg::CKS_RESET
                                         : sys_clock_select_ff;
   assign watchdog_clear = watchdog_clear_ff;
   assign power_down_flag = power_down_flag_ff;
   assign watchdog_timeout_flag = watchdog_timeout_flag_ff;

   // Read data; upper crystal control bits are zero.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 8'h00;
      end else if (rd) begin
         case (addr)
            ocp_pkg::FAST_XTAL_ADDR: rdata_ff <= {5'h00,
               fast_xtal_drive_sel_ff, fast_xtal_stable_flag_ff,
               fast_xtal_enable_ff};
            ocp_pkg::SLOW_XTAL_ADDR: rdata_ff <= {5'h00,
               slow_xtal_speedup_ff, slow_xtal_stable_flag_ff,
               slow_xtal_enable_ff};
            ocp_pkg::SYS_CFG_ADDR: rdata_ff <= {sys_clock_select_ff, 1'b0,
               low_freq_source_sel_ff, 1'b0, fast_osc_keepalive_ff,
               slow_osc_keepalive_ff};
            ocp_pkg::STATUS_ADDR: rdata_ff <= {1'b0, mode_ff, 1'b0,
               on_sub_ff, watchdog_timeout_flag_ff, power_down_flag_ff};
            default: rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end
   assign rdata = rdata_ff;
endmodule : ocp_ctrl

// [src/ocp_pkg.sv]
// Constants, register map and types for the oscillator and power mode control.
// Function
// - Drive select 0 picks weak drive up to 10MHz, 1 strong drive above.
// - Drive select write ignored while crystal pins enabled and fast crystal on.
// - Enabling fast crystal clears its stable flag, then sets it when stable.
// - Fast crystal enable runs oscillator at 1, stops at 0, resets to 0.
// - Slow crystal speed-up 1 fast start high power, 0 low power slower.
// - Speed-up bit frozen while slow crystal is the system clock.
// - Enabling slow crystal clears its stable flag, then sets it when stable.
// - Slow crystal enable runs oscillator at 1; stable flags are read-only.
// - Bits 7 to 3 of both crystal control registers read as zero.
// - Clock select 111 moves system clock to the sub clock, slow mode.
// - Slow mode switch completes only when chosen low-speed source is stable.
// - Clock select 000 to 110 picks fast clock divided by 1 to 64.
// - Halt with both keep-alive bits 0 enters sleep; all clocks stop.
// - Halt with fast 0, slow 1 stops fast clock, keeps sub clock.
// - Halt with both keep-alive bits 1 keeps both clocks running.
// - Entering sleep or idle sets power-down flag, clears timeout flag.
// - Entering sleep or idle clears watchdog counter.
// - Memory, registers and ports hold their state in sleep or idle; a crystal stopped by the halt clears its stable flag.
// - Low-frequency select 0 picks internal RC, 1 slow crystal.
// - Halt with fast 1, slow 0 keeps fast clock, stops sub clock.
package ocp_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] FAST_XTAL_ADDR = 4'h0;
   localparam logic [3:0] SLOW_XTAL_ADDR = 4'h1;
   localparam logic [3:0] SYS_CFG_ADDR = 4'h2;
   localparam logic [3:0] STATUS_ADDR = 4'h3;
   localparam int EN_BIT = 0;
   localparam int FLAG_BIT = 1;
   localparam int MODE_BIT = 2;
   localparam int KEEP_SLOW_BIT = 0;
   localparam int KEEP_FAST_BIT = 1;
   localparam int LFSEL_BIT = 3;
   localparam int CKS_LSB = 5;
   localparam int PDF_BIT = 0;
   localparam int TO_BIT = 1;
   localparam int SLOW_MODE_BIT = 2;
   localparam int MODE_LSB = 4;
   localparam logic [7:0] XTAL_RESET = 8'h00;
   localparam logic [7:0] SYS_CFG_RESET = 8'h00;
   localparam logic [2:0] CKS_SUB = 3'h7;
   localparam logic [2:0] CKS_RESET = 3'h0;
   localparam int FAST_STABLE_US = 1;
   localparam int SLOW_STABLE_US = 20;
   localparam int SLOW_SPEEDUP_US = 2;
   localparam int CLK_MHZ = 100;
   localparam int FAST_STABLE_CYC = FAST_STABLE_US * CLK_MHZ;
   localparam int SLOW_STABLE_CYC = SLOW_STABLE_US * CLK_MHZ;
   localparam int SLOW_SPEEDUP_CYC = SLOW_SPEEDUP_US * CLK_MHZ;
   localparam int CNT_W = 12;
   typedef enum logic [2:0] {
      OCP_FAST, OCP_SLOW, OCP_SLEEP, OCP_IDLE_SUB, OCP_IDLE_BOTH, OCP_IDLE_HIGH
   } ocp_mode_type;
endpackage : ocp_pkg

// [verif/ocp_osc_model.sv]
// Model of the internal RC oscillators that sit beside the block.
`timescale 1ns/100ps
module ocp_osc_model #(
   parameter int RC_CYC = 30
) (
   input wire logic clk,
   input wire logic resetn,
   output logic slow_rc_stable,
   output logic fast_rc_stable
);
   int cnt_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= 0;
      end else if (cnt_ff < RC_CYC) begin
         cnt_ff <= cnt_ff + 1;
      end
   end
   assign slow_rc_stable = (cnt_ff == RC_CYC);
   assign fast_rc_stable = slow_rc_stable;
endmodule : ocp_osc_model

// [verif/ocp_ctrl_asserts.sv]
// Concurrent checks on the ports of the oscillator and power mode control.
`timescale 1ns/100ps
module ocp_ctrl_asserts (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic crystal_pins_enabled,
   input wire logic slow_rc_stable,
   input wire logic halt_exec,
   input wire logic wake,
   input wire logic fast_crystal_osc_run,
   input wire logic fast_xtal_strong_drive,
   input wire logic slow_xtal_speedup_out,
   input wire logic fast_clock_run,
   input wire logic sub_clock_run,
   input wire logic sys_clock_on_sub,
   input wire logic [2:0] fast_clock_div_sel,
   input wire logic cpu_halted,
   input wire logic watchdog_clear,
   input wire logic power_down_flag,
   input wire logic watchdog_timeout_flag
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_drive_locked: assert property (
      wr && addr == ocp_pkg::FAST_XTAL_ADDR && crystal_pins_enabled &&
      fast_crystal_osc_run |=> $stable(fast_xtal_strong_drive))
      else $error("drive select changed while locked");
   a_drive_write: assert property (
      wr && addr == ocp_pkg::FAST_XTAL_ADDR && !crystal_pins_enabled |=>
      fast_xtal_strong_drive == $past(wdata[ocp_pkg::MODE_BIT]))
      else $error("drive select not written");
   a_upper_zero: assert property (
      rd && (addr == ocp_pkg::FAST_XTAL_ADDR ||
      addr == ocp_pkg::SLOW_XTAL_ADDR) |=> rdata[7:3] == 5'h00)
      else $error("upper control bits not zero");
   a_slow_entry: assert property (
      wr && addr == ocp_pkg::SYS_CFG_ADDR && wdata[7:5] == ocp_pkg::CKS_SUB
      && !wdata[ocp_pkg::LFSEL_BIT] && slow_rc_stable |-> ##2 sys_clock_on_sub)
      else $error("slow mode not entered");
   a_fast_div: assert property (
      wr && addr == ocp_pkg::SYS_CFG_ADDR && wdata[7:5] != ocp_pkg::CKS_SUB
      |-> ##2 !sys_clock_on_sub && fast_clock_div_sel == $past(wdata[7:5], 2))
      else $error("divider select wrong");
   a_clk_source: assert property (
      !cpu_halted |-> (sys_clock_on_sub ? sub_clock_run : fast_clock_run))
      else $error("running clock does not match mode");
   a_halt_entry: assert property (
      halt_exec && !cpu_halted |=> cpu_halted && power_down_flag &&
      !watchdog_timeout_flag && watchdog_clear ##1 !watchdog_clear)
      else $error("halt entry effects wrong");
   a_halt_hold: assert property (
      cpu_halted && !wake && !wr |=> cpu_halted &&
      $stable(fast_xtal_strong_drive) && $stable(slow_xtal_speedup_out))
      else $error("state changed while halted");
   a_wake_exit: assert property (
      cpu_halted && wake |=> !cpu_halted)
      else $error("wake did not leave halt");
endmodule : ocp_ctrl_asserts
bind ocp_ctrl ocp_ctrl_asserts ocp_ctrl_asserts_inst (.clk, .resetn, .addr,
   .wdata, .wr, .rd, .rdata, .crystal_pins_enabled, .slow_rc_stable,
   .halt_exec, .wake, .fast_crystal_osc_run, .fast_xtal_strong_drive,
   .slow_xtal_speedup_out, .fast_clock_run, .sub_clock_run, .sys_clock_on_sub,
   .fast_clock_div_sel, .cpu_halted, .watchdog_clear, .power_down_flag,
   .watchdog_timeout_flag);

// [verif/tb.sv]
// Self-checking bench for the oscillator and power mode control.
`timescale 1ns/100ps
module tb;
   logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, wake = 1'b0;
   logic crystal_pins_enabled = 1'b0, halt_exec = 1'b0;
   logic watchdog_timeout = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, d;
   logic slow_rc_stable, fast_rc_stable, fast_crystal_osc_run;
   logic fast_xtal_strong_drive, slow_crystal_osc_run, slow_xtal_speedup_out;
   logic fast_clock_run, sub_clock_run, sys_clock_on_sub, cpu_halted;
   logic watchdog_clear, power_down_flag, watchdog_timeout_flag;
   logic [2:0] fast_clock_div_sel;
   int err_total = 0, num_checks = 0, cycles = 0, n;
   ocp_ctrl ocp_ctrl_inst (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
      .crystal_pins_enabled, .slow_rc_stable, .fast_rc_stable, .halt_exec,
      .wake, .fast_crystal_osc_run, .fast_xtal_strong_drive,
      .slow_crystal_osc_run, .slow_xtal_speedup_out, .fast_clock_run,
      .sub_clock_run, .sys_clock_on_sub, .fast_clock_div_sel, .cpu_halted,
      .watchdog_clear, .power_down_flag, .watchdog_timeout_flag,
      .watchdog_timeout);
   ocp_osc_model ocp_osc_model_inst (.clk, .resetn, .slow_rc_stable,
      .fast_rc_stable);
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic results();
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total = err_total + 1;
         results();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic poll(input logic [3:0] a);
      n = 0;
      d = 8'h00;
      while (d[ocp_pkg::FLAG_BIT] !== 1'b1 && n < 3000) begin
         rd_reg(a);
         n = n + 2;
      end
   endtask : poll
   task automatic halt_to(input logic [1:0] k, input logic [2:0] m,
      input logic [1:0] c);
      poll(ocp_pkg::FAST_XTAL_ADDR);
      wr_reg(ocp_pkg::SYS_CFG_ADDR, {6'h00, k});
      @(posedge clk);
      watchdog_timeout <= 1'b1;
      @(posedge clk);
      watchdog_timeout <= 1'b0;
      halt_exec <= 1'b1;
      #1 chk({7'h00, watchdog_timeout_flag}, 8'h01);
      @(posedge clk);
      halt_exec <= 1'b0;
      #1 chk({fast_clock_run, sub_clock_run, cpu_halted, power_down_flag,
         watchdog_timeout_flag, watchdog_clear, 2'b00},
         {c, 6'b110100});
      rd_reg(ocp_pkg::STATUS_ADDR);
      chk(d, {1'b0, m, 4'h1});
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      rd_reg(ocp_pkg::STATUS_ADDR);
      chk(d, 8'h01);
      rd_reg(ocp_pkg::FAST_XTAL_ADDR);
      chk(d, {5'h00, 1'b1, k[1], 1'b1});
   endtask : halt_to
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd_reg(4'(i));
         chk(d, 8'h00);
      end
      rd_reg(4'hf);
      chk(d, 8'h00);
      wr_reg(ocp_pkg::FAST_XTAL_ADDR, 8'hff);
      rd_reg(ocp_pkg::FAST_XTAL_ADDR);
      chk(d, 8'h05);
      poll(ocp_pkg::FAST_XTAL_ADDR);
      chk({7'h00, (n inside {[92:108]})}, 8'h01);
      crystal_pins_enabled <= 1'b1;
      wr_reg(ocp_pkg::FAST_XTAL_ADDR, 8'h01);
      rd_reg(ocp_pkg::FAST_XTAL_ADDR);
      chk(d, 8'h07);
      crystal_pins_enabled <= 1'b0;
      wr_reg(ocp_pkg::FAST_XTAL_ADDR, 8'h00);
      rd_reg(ocp_pkg::FAST_XTAL_ADDR);
      chk(d, 8'h00);
      chk({6'h00, fast_xtal_strong_drive, fast_crystal_osc_run}, 8'h00);
      wr_reg(ocp_pkg::FAST_XTAL_ADDR, 8'h04);
      wr_reg(ocp_pkg::FAST_XTAL_ADDR, 8'h05);
      poll(ocp_pkg::FAST_XTAL_ADDR);
      chk(d, 8'h07);
      wr_reg(ocp_pkg::SLOW_XTAL_ADDR, 8'h05);
      poll(ocp_pkg::SLOW_XTAL_ADDR);
      chk({7'h00, (n inside {[192:208]})}, 8'h01);
      chk({6'h00, slow_xtal_speedup_out, slow_crystal_osc_run}, 8'h03);
      wr_reg(ocp_pkg::SYS_CFG_ADDR, 8'he0);
      @(posedge clk);
      rd_reg(ocp_pkg::STATUS_ADDR);
      chk(d, 8'h14);
      chk({4'h0, sys_clock_on_sub, fast_clock_div_sel}, 8'h08);
      wr_reg(ocp_pkg::SYS_CFG_ADDR, 8'he8);
      wr_reg(ocp_pkg::SLOW_XTAL_ADDR, 8'h03);
      rd_reg(ocp_pkg::SLOW_XTAL_ADDR);
      chk(d, 8'h07);
      poll(ocp_pkg::FAST_XTAL_ADDR);
      for (int i = 0; i < 7; i++) begin
         wr_reg(ocp_pkg::SYS_CFG_ADDR, {3'(i), 5'h00});
         @(posedge clk);
         #1 chk({4'h0, sys_clock_on_sub, fast_clock_div_sel}, 8'(i));
      end
      halt_to(2'b00, ocp_pkg::OCP_SLEEP, 2'b00);
      halt_to(2'b01, ocp_pkg::OCP_IDLE_SUB, 2'b01);
      halt_to(2'b11, ocp_pkg::OCP_IDLE_BOTH, 2'b11);
      halt_to(2'b10, ocp_pkg::OCP_IDLE_HIGH, 2'b10);
      results();
   end
endmodule : tb
